// [sfg_pkg.sv]
package sfg_pkg;

  // ----------------------------------------------------------------
  // word formats
  // ----------------------------------------------------------------
  localparam int RAW_W      = 14;          // converter sample width
  localparam int WORD_W     = 16;          // internal sample word width
  localparam int PAD_W      = WORD_W - RAW_W;  // zero bits under the sample
  localparam int GAIN_W     = 16;          // unsigned gain, unity at 1024
  localparam int GAIN_FRAC  = 10;          // gain is divided by 2**10
  localparam int SEL_W      = 8;           // channel selector width
  localparam int SEL_RAW_BIT = 7;          // selector bit that drops calibration
  localparam int TIME_W     = 48;          // sample time stamp width

  // ----------------------------------------------------------------
  // code limits and reset values
  // ----------------------------------------------------------------
  localparam logic signed [15:0] CODE_MAX   = 16'sh7fff;  // 32 767
  localparam logic signed [15:0] CODE_MIN   = -16'sh8000; // -32 768
  localparam logic [15:0]        GAIN_UNITY = 16'h0400;   // 1024
  localparam logic [15:0]        GAIN_MAX   = 16'hffff;
  localparam logic signed [15:0] OFFS_ZERO  = 16'sh0000;

  // ----------------------------------------------------------------
  // analog scale: half the span maps to 2**15 codes
  // ----------------------------------------------------------------
  localparam int FS_SPAN_MV    = 1000;     // 1 Vpp, centred on zero
  localparam int HALF_SCALE    = 32768;    // 2**15

  // ----------------------------------------------------------------
  // clocks
  // ----------------------------------------------------------------
  localparam int DATA_CLK_KHZ  = 312500;   // data clock, 312.5 MHz
  localparam int TRIG_CLK_KHZ  = 20000000; // trigger clock, 20 GHz
  localparam int TRIG_TICKS_PER_CLK = TRIG_CLK_KHZ / DATA_CLK_KHZ;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef enum logic [0:0] {
    SFG_MODE_DUAL   = 1'b0,   // two channels at 5 GSPS
    SFG_MODE_SINGLE = 1'b1    // one channel at 10 GSPS
  } sfg_mode_t;

  typedef struct packed {
    logic             valid;
    logic [RAW_W-1:0] data;
  } sfg_raw_t;

  typedef struct packed {
    logic              valid;
    logic              ovf;
    logic [WORD_W-1:0] data;
  } sfg_word_t;

  typedef struct packed {
    logic [SEL_W-1:0]  sel;
    logic [GAIN_W-1:0] user_gain;
    logic [WORD_W-1:0] user_offset;
    logic [GAIN_W-1:0] cal_gain;
    logic [WORD_W-1:0] cal_offset;
  } sfg_setting_t;

  typedef struct packed {
    logic [GAIN_W-1:0] gain;
    logic [WORD_W-1:0] offset;
    logic              sat;
  } sfg_coef_t;

endpackage

// [sfg_gain_stage.sv]
`timescale 1ns/1ps
module sfg_gain_stage (
  // clock and reset
  input  wire logic              sys_clk_i,
  input  wire logic              rst_i,
  // formatted sample and coefficients
  input  wire sfg_pkg::sfg_word_t word_i,
  input  wire sfg_pkg::sfg_coef_t coef_i,
  // corrected sample
  output sfg_pkg::sfg_word_t      word_o
);
  import sfg_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    sfg_word_t out;               // registered corrected word
  } sfg_gst_t;

  sfg_gst_t            st_q;      // registered state
  sfg_gst_t            st_d;      // next state
  logic signed [32:0]  prod;      // sample times gain
  logic signed [22:0]  scaled;    // product divided by 1024
  logic signed [23:0]  diff;      // scaled minus offset

  // ----------------------------------------------------------------
  // arithmetic
  // ----------------------------------------------------------------
  // multiply, drop ten fraction bits, subtract offset, then clamp
  always_comb begin
    st_d   = st_q;
    prod   = $signed(word_i.data) * $signed({1'b0, coef_i.gain});
    // floor keeps the sub-14-bit fraction in the two low bits
    scaled = prod[32:GAIN_FRAC];
    diff   = {scaled[22], scaled} - {{8{coef_i.offset[15]}}, coef_i.offset};
    st_d.out.valid = word_i.valid;
    st_d.out.ovf   = word_i.valid & (word_i.ovf | coef_i.sat);
    if (diff > 24'(CODE_MAX)) begin
      // positive overflow clamps to full scale
      st_d.out.data = CODE_MAX;
      st_d.out.ovf  = word_i.valid;
    end else if (diff < 24'(signed'(CODE_MIN))) begin
      // negative overflow clamps to minus full scale
      st_d.out.data = CODE_MIN;
      st_d.out.ovf  = word_i.valid;
    end else begin
      st_d.out.data = diff[15:0];
    end
  end

  // ----------------------------------------------------------------
  // register
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign word_o = st_q.out;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  AST_SAT_FLAG: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (word_i.valid && (diff > 24'(CODE_MAX) || diff < 24'(signed'(CODE_MIN))))
      |=> (word_o.ovf && (word_o.data == CODE_MAX || word_o.data == CODE_MIN)))
    else $error("out of range result not clamped with flag");

  AST_UNITY_PASS: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (word_i.valid && coef_i.gain == GAIN_UNITY && coef_i.offset == OFFS_ZERO)
      |=> (word_o.data == $past(word_i.data)))
    else $error("unity gain without offset changed the sample");

endmodule

// [sfg_top.sv]
`timescale 1ns/1ps
module sfg_top #(
  parameter int LANES = 2                  // converter lanes
) (
  // clock and reset
  input  wire logic                        sys_clk_i,
  input  wire logic                        rst_i,
  // firmware mode strap, held static while running
  input  wire logic                        mode_single_i,
  // gain and offset settings, loaded on the strobe
  input  wire logic                        set_valid_i,
  input  wire sfg_pkg::sfg_setting_t       set_i,
  // raw converter samples, one per lane per cycle
  input  wire sfg_pkg::sfg_raw_t [LANES-1:0] raw_i,
  // corrected samples
  output sfg_pkg::sfg_word_t [LANES-1:0]     word_o,
  // status
  output sfg_pkg::sfg_mode_t               mode_o,
  output logic [sfg_pkg::TIME_W-1:0]       time_o
);
  import sfg_pkg::*;

  // ----------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------
  if (LANES < 1 || LANES > 8) begin : g_bad_lanes
    $error("LANES must lie between 1 and 8");
  end

  // a full-scale code stands for half the analog span, so the top code
  // weight of the word must equal the half-scale count
  if (HALF_SCALE != 2 ** (WORD_W - 1)) begin : g_bad_scale
    $error("half scale must equal the top code weight of the word");
  end

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic                     armed;   // mode strap already caught
    sfg_mode_t                mode;    // firmware mode, fixed after catch
    sfg_setting_t             active;  // setting in force
    sfg_coef_t                coef;    // combined gain and offset
    sfg_word_t [LANES-1:0]    fmt;     // formatted samples
    logic [TIME_W-1:0]        tstamp;  // data clock time in trigger ticks
  } sfg_st_t;

  sfg_st_t                 st_q;       // registered state
  sfg_st_t                 st_d;       // next state
  sfg_word_t [LANES-1:0]   corr;       // corrected words from the lanes

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // lane is in use in the current mode; single mode feeds lane 0 only
  function automatic logic lane_on(input sfg_mode_t m, input int idx);
    return (m == SFG_MODE_DUAL) || (idx == 0);
  endfunction

  // calibrated times user gain over 1024, clamped to the gain range
  function automatic logic [GAIN_W:0] mul_gain(input logic [GAIN_W-1:0] a,
                                               input logic [GAIN_W-1:0] b);
    logic [31:0] p;
    logic [21:0] s;
    p = a * b;
    s = p[31:GAIN_FRAC];
    if (s > 22'(GAIN_MAX)) begin
      return {1'b1, GAIN_MAX};
    end
    return {1'b0, s[15:0]};
  endfunction

  // sum of two offsets, clamped to the signed word range
  function automatic logic [WORD_W:0] add_offs(input logic [WORD_W-1:0] a,
                                               input logic [WORD_W-1:0] b);
    logic signed [16:0] s;
    s = $signed({a[15], a}) + $signed({b[15], b});
    if (s > 17'(CODE_MAX)) begin
      return {1'b1, CODE_MAX};
    end
    if (s < 17'(signed'(CODE_MIN))) begin
      return {1'b1, CODE_MIN};
    end
    return {1'b0, s[15:0]};
  endfunction

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [GAIN_W:0] g;
    logic [WORD_W:0] o;
    g    = '0;
    o    = '0;
    st_d = st_q;

    // catch the firmware mode once, after reset has gone
    if (!st_q.armed) begin
      st_d.armed = 1'b1;
      st_d.mode  = sfg_mode_t'(mode_single_i);
    end

    // a new setting replaces the whole set in one edge, so no sample
    // ever sees a gain from one call and an offset from another
    if (set_valid_i) begin
      st_d.active = set_i;
    end

    // combine settings; the factory values undo the front-end error
    if (st_q.active.sel[SEL_RAW_BIT]) begin
      // calibration ignored, user values act on the raw sample
      st_d.coef.gain   = st_q.active.user_gain;
      st_d.coef.offset = st_q.active.user_offset;
      st_d.coef.sat    = 1'b0;
    end else begin
      g = mul_gain(st_q.active.cal_gain, st_q.active.user_gain);
      o = add_offs(st_q.active.cal_offset, st_q.active.user_offset);
      st_d.coef.gain   = g[15:0];
      st_d.coef.offset = o[15:0];
      // a clamped coefficient marks every sample it touches
      st_d.coef.sat    = g[16] | o[16];
    end

    // place each sample at the top of the word; half span is 2**15
    for (int i = 0; i < LANES; i++) begin
      st_d.fmt[i].valid = raw_i[i].valid & lane_on(st_q.mode, i);
      st_d.fmt[i].ovf   = 1'b0;
      st_d.fmt[i].data  = {raw_i[i].data, {PAD_W{1'b0}}};
    end

    // time of the data clock edge counted in trigger clock ticks
    st_d.tstamp = st_q.tstamp + TIME_W'(TRIG_TICKS_PER_CLK);
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  // everything here runs on the data clock; sampling, trigger and host
  // clocks live outside and cross into this domain elsewhere
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_q                  <= '0;
      // unity gain and no offset keep the default span centred on zero
      st_q.active.user_gain <= GAIN_UNITY;
      st_q.active.cal_gain  <= GAIN_UNITY;
      st_q.coef.gain        <= GAIN_UNITY;
    end else begin
      st_q <= st_d;
    end
  end

  // ----------------------------------------------------------------
  // lanes
  // ----------------------------------------------------------------
  // one correction stage per lane, each takes a word every cycle
  for (genvar l = 0; l < LANES; l++) begin : g_lane
    sfg_gain_stage u_gain (
      .sys_clk_i (sys_clk_i),
      .rst_i     (rst_i),
      .word_i    (st_q.fmt[l]),
      .coef_i    (st_q.coef),
      .word_o    (corr[l])
    );
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // words are signed two's complement, clamped to full scale
  assign word_o = corr;
  assign mode_o = st_q.mode;
  // time stamp steps by 64 trigger ticks every cycle and carries no valid
  assign time_o = st_q.tstamp;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  AST_LSB_ZERO: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    st_q.fmt[0].valid |-> (st_q.fmt[0].data[PAD_W-1:0] == '0 &&
                           st_q.fmt[0].data[WORD_W-1:PAD_W] == $past(raw_i[0].data)))
    else $error("formatted sample not placed at the top of the word");

  AST_LATENCY: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (st_q.armed && raw_i[0].valid) |-> ##2 word_o[0].valid)
    else $error("lane 0 word did not appear two cycles later");

  AST_NO_SPURIOUS: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    word_o[0].valid |-> $past(raw_i[0].valid, 2))
    else $error("lane 0 produced a word with no sample behind it");

  AST_RAW_MODE: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    st_q.active.sel[SEL_RAW_BIT] |=>
      (st_q.coef.gain == $past(st_q.active.user_gain) &&
       st_q.coef.offset == $past(st_q.active.user_offset)))
    else $error("calibration not bypassed when selector bit set");

  AST_CAL_UNITY: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (!st_q.active.sel[SEL_RAW_BIT] && st_q.active.cal_gain == GAIN_UNITY)
      |=> (st_q.coef.gain == $past(st_q.active.user_gain)))
    else $error("unity calibration altered the user gain");

  AST_SET_TAKE: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    set_valid_i |=> (st_q.active == $past(set_i)) ##1 (st_q.coef.gain != 16'h0000 ||
      $past(st_q.active.user_gain) == 16'h0000 || $past(st_q.active.cal_gain) < 16'h0040
      || $past(st_q.active.sel[SEL_RAW_BIT]) == 1'b0))
    else $error("setting not taken on the following edge");

  AST_MODE_FIXED: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    $past(st_q.armed) |-> $stable(st_q.mode))
    else $error("mode changed without a reset");

  AST_SINGLE_IDLE: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (st_q.mode == SFG_MODE_SINGLE && st_q.armed) |-> ##1 !st_q.fmt[LANES-1].valid
      || LANES == 1)
    else $error("unused lane active in single channel mode");

  AST_TICKS: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    $past(st_q.armed) |-> (time_o - $past(time_o) == TIME_W'(TRIG_TICKS_PER_CLK)))
    else $error("time stamp did not advance by 64 trigger ticks");

endmodule

// [sfg_adc_model.sv]
`timescale 1ns/1ps
// ----------------------------------------------------------------
// converter core model: one registered sample per lane per cycle
// ----------------------------------------------------------------
module sfg_adc_model #(
  parameter int LANES = 2                              // converter lanes
) (
  // clock and reset
  input  wire logic                                    sys_clk_i,
  input  wire logic                                    rst_i,
  // sample requests from the bench
  input  wire logic [LANES-1:0]                        req_valid_i,
  input  wire logic [LANES-1:0][sfg_pkg::RAW_W-1:0]    req_data_i,
  // converter output words
  output sfg_pkg::sfg_raw_t [LANES-1:0]                raw_o
);
  import sfg_pkg::*;

  // a lane that holds no sample flips its data every cycle, so a
  // design that samples data without valid cannot see a stale match
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      raw_o <= '0;
    end else begin
      for (int l = 0; l < LANES; l++) begin
        raw_o[l].valid <= req_valid_i[l];
        if (req_valid_i[l]) begin
          raw_o[l].data <= req_data_i[l];
        end else begin
          raw_o[l].data <= ~raw_o[l].data;
        end
      end
    end
  end
endmodule

// [tb_top.sv]
`timescale 1ns/1ps
module tb_top;
  import sfg_pkg::*;

  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic                  sys_clk_i     = 1'b0;  // data clock
  logic                  rst_i         = 1'b1;  // async reset
  logic                  mode_single_i = 1'b0;  // mode strap
  logic                  set_valid_i   = 1'b0;  // setting strobe
  sfg_setting_t          set_i         = '0;    // setting bundle
  logic [1:0]            req_v         = '0;    // model requests
  logic [1:0][RAW_W-1:0] req_d         = '0;    // model request data
  sfg_raw_t [1:0]        raw_w;                 // converter words
  sfg_word_t [1:0]       word_w;                // corrected words
  sfg_mode_t             mode_w;                // caught mode
  logic [TIME_W-1:0]     time_w;                // time stamp
  int                    n_mismatch    = 0;     // failed compares
  int                    checks_done   = 0;     // all compares
  logic [31:0]           rng_q         = 32'h04d91f8c;  // xorshift state
  int unsigned           g_e;                   // expected gain
  longint                off_e;                 // expected offset
  logic                  sat_e, mode_e;         // coef clamp, mode
  longint                cyc           = 0;     // cycle counter
  sfg_word_t             exp_q[2][$];           // expected words
  longint                stamp_q[2][$];         // entry cycles
  logic [RAW_W-1:0]      corner[4] = '{14'h1fff, 14'h2000, 14'h0000, 14'h3fff};

  initial begin
    forever #5 sys_clk_i = ~sys_clk_i;
  end

  sfg_adc_model #(.LANES(2)) sfg_adc_model_i (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i), .req_valid_i(req_v),
    .req_data_i(req_d), .raw_o(raw_w));

  sfg_top #(.LANES(2)) sfg_top_i (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i), .mode_single_i(mode_single_i),
    .set_valid_i(set_valid_i), .set_i(set_i), .raw_i(raw_w),
    .word_o(word_w), .mode_o(mode_w), .time_o(time_w));

  // ----------------------------------------------------------------
  // reference arithmetic
  // ----------------------------------------------------------------
  function automatic logic [31:0] rnd();
    rng_q = rng_q ^ (rng_q << 13);
    rng_q = rng_q ^ (rng_q >> 17);
    rng_q = rng_q ^ (rng_q << 5);
    return rng_q;
  endfunction

  // combine user and calibration values the way the block must
  function automatic void set_coef(input sfg_setting_t s);
    longint gg;
    sat_e = 1'b0;
    if (s.sel[SEL_RAW_BIT]) begin
      g_e   = s.user_gain;
      off_e = longint'($signed(s.user_offset));
    end else begin
      gg    = (longint'(s.cal_gain) * longint'(s.user_gain)) >>> 10;
      off_e = longint'($signed(s.cal_offset)) + longint'($signed(s.user_offset));
      if (gg > 65535) begin
        gg    = 65535;
        sat_e = 1'b1;
      end
      if (off_e > 32767) begin
        off_e = 32767;
        sat_e = 1'b1;
      end else if (off_e < -32768) begin
        off_e = -32768;
        sat_e = 1'b1;
      end
      g_e = gg[31:0];
    end
  endfunction

  // floor of the product keeps the fraction in the two low bits
  function automatic sfg_word_t predict(input logic [RAW_W-1:0] raw);
    longint    r;
    sfg_word_t w;
    r = ((longint'($signed({raw, 2'b00})) * longint'(g_e)) >>> 10) - off_e;
    w.valid = 1'b1;
    w.ovf   = sat_e;
    if (r > 32767) begin
      r     = 32767;
      w.ovf = 1'b1;
    end else if (r < -32768) begin
      r     = -32768;
      w.ovf = 1'b1;
    end
    w.data = r[15:0];
    return w;
  endfunction

  // ----------------------------------------------------------------
  // compare and closing tasks
  // ----------------------------------------------------------------
  task automatic cmp_word(input string nm, input sfg_word_t e, input sfg_word_t g);
    checks_done++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic cmp_val(input string nm, input logic [63:0] e, input logic [63:0] g);
    checks_done++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic summarize();
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // scoreboard: predict at the converter, check at the output
  // ----------------------------------------------------------------
  always @(posedge sys_clk_i) begin
    cyc <= cyc + 1;
    if (rst_i) begin
      for (int l = 0; l < 2; l++) begin
        exp_q[l].delete();
        stamp_q[l].delete();
      end
    end else begin
      for (int l = 0; l < 2; l++) begin
        if (word_w[l].valid === 1'b1) begin
          if (exp_q[l].size() == 0) begin
            cmp_word("word_o unexpected", '0, word_w[l]);
          end else begin
            cmp_word("word_o", exp_q[l].pop_front(), word_w[l]);
            cmp_val("latency", 64'd2, 64'(cyc - stamp_q[l].pop_front()));
          end
        end
        // single mode keeps lane 0 only
        if (raw_w[l].valid && (l == 0 || !mode_e)) begin
          exp_q[l].push_back(predict(raw_w[l].data));
          stamp_q[l].push_back(cyc);
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // stimulus tasks
  // ----------------------------------------------------------------
  task automatic do_reset(input logic m);
    logic [TIME_W-1:0] t0;
    @(posedge sys_clk_i);
    rst_i         <= 1'b1;
    mode_single_i <= m;
    repeat (12) @(posedge sys_clk_i);
    @(negedge sys_clk_i);
    cmp_val("time_o reset", 64'd0, 64'(time_w));
    cmp_val("mode_o reset", 64'd0, 64'(mode_w));
    cmp_val("word_o reset", 64'd0, 64'(word_w));
    @(posedge sys_clk_i);
    rst_i  <= 1'b0;
    mode_e  = m;
    set_coef('{8'h00, GAIN_UNITY, 16'h0000, GAIN_UNITY, 16'h0000});
    repeat (3) @(posedge sys_clk_i);
    @(negedge sys_clk_i);
    cmp_val("mode_o", 64'(m), 64'(mode_w));
    t0 = time_w;
    repeat (10) @(negedge sys_clk_i);
    cmp_val("time_o", 64'(t0 + TIME_W'(10 * TRIG_TICKS_PER_CLK)), 64'(time_w));
  endtask

  // settings land only while the pipeline is empty
  task automatic apply(input sfg_setting_t s);
    @(posedge sys_clk_i);
    set_valid_i <= 1'b1;
    set_i       <= s;
    @(posedge sys_clk_i);
    set_valid_i <= 1'b0;
    set_coef(s);
    repeat (4) @(posedge sys_clk_i);
  endtask

  // random samples, valid on three cycles in four on average, with full-scale corners mixed in
  task automatic burst(input int n);
    logic [31:0] r;
    for (int i = 0; i < n; i++) begin
      @(posedge sys_clk_i);
      for (int l = 0; l < 2; l++) begin
        r = rnd();
        req_v[l] <= (r[1:0] != 2'b00);
        req_d[l] <= (r[4:2] == 3'b000) ? corner[r[6:5]] : r[29:16];
      end
    end
    @(posedge sys_clk_i);
    req_v <= '0;
    repeat (6) @(posedge sys_clk_i);
    // every predicted word must have come out by now
    for (int l = 0; l < 2; l++) begin
      cmp_val("pending words", 64'd0, 64'(exp_q[l].size()));
    end
  endtask

  // ----------------------------------------------------------------
  // main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    sfg_setting_t tbl[6];
    logic [95:0]  rw;  // three random words, drawn in a fixed order
    tbl[0] = '{8'h00, 16'h0400, 16'h0000, 16'h0427, 16'h0000};  // 1063 calibration
    tbl[1] = '{8'h80, 16'h0800, 16'h0100, 16'h0001, 16'h7000};  // user only, 2x
    tbl[2] = '{8'h00, 16'hffff, 16'h0000, 16'hffff, 16'h0000};  // gain clamps
    tbl[3] = '{8'h01, 16'h0400, 16'h7fff, 16'h0400, 16'h7fff};  // offset clamps
    tbl[4] = '{8'h80, 16'h0200, 16'h8000, 16'h0400, 16'h0000};  // minus full scale
    tbl[5] = '{8'h00, 16'h0399, 16'hfff3, 16'h0411, 16'h0025};  // fine trim
    do_reset(1'b0);
    burst(40);
    foreach (tbl[i]) begin
      apply(tbl[i]);
      burst(30);
    end
    repeat (4) begin
      rw[95:64] = rnd();
      rw[63:32] = rnd();
      rw[31:0]  = rnd();
      apply(sfg_setting_t'(rw[71:0]));
      burst(30);
    end
    do_reset(1'b1);
    burst(40);
    apply(tbl[0]);
    burst(30);
    summarize();
  end

  // the whole run needs well under 2000 cycles
  initial begin
    repeat (20000) @(posedge sys_clk_i);
    n_mismatch++;
    summarize();
  end
endmodule
